// ===== pkg/sensor_status_pkg.sv
package sensor_status_pkg;

	// Clock and timing.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned FLICKER_MS = 50;
	localparam int unsigned BLINK_MS = 200;
	localparam int unsigned FLASH_OFF_MS = 1000;
	localparam int unsigned CYC_50MS = FLICKER_MS * CYC_PER_MS;
	// Pattern steps counted in 50 ms units and 200 ms units.
	localparam int unsigned UNITS_PER_STEP = BLINK_MS / FLICKER_MS;
	localparam int unsigned SF_STEPS = 1 + FLASH_OFF_MS / BLINK_MS;
	localparam int unsigned DF_STEPS = 3 + FLASH_OFF_MS / BLINK_MS;

	// Sensor layout.
	localparam int unsigned MAX_SENSORS = 16;
	localparam int unsigned SAMPLES_NEEDED = 4;
	localparam int unsigned FILTER_DIV = 4;

	// Input image byte offsets.
	localparam logic [2:0] OFS_SENSOR_BITS_1_TO_4 = 3'h0;
	localparam logic [2:0] OFS_SENSOR_BITS_5_TO_8 = 3'h1;
	localparam logic [2:0] OFS_SENSOR_BITS_9_TO_12 = 3'h2;
	localparam logic [2:0] OFS_SENSOR_BITS_13_TO_16 = 3'h3;
	localparam logic [2:0] OFS_UNIT_STATUS_FLAGS = 3'h4;
	localparam logic [2:0] OFS_CONFIGURED_SENSOR_COUNT = 3'h5;
	localparam logic [2:0] OFS_PADDED_SENSOR_COUNT = 3'h6;

	// Status flag bit positions.
	localparam int unsigned BIT_BUSY = 0;
	localparam int unsigned BIT_SENSOR_FAULT = 1;

	// Mailbox object indices.
	localparam logic [15:0] OBJ_FILTER_TIME = 16'h3002;
	localparam logic [15:0] OBJ_DUMMY_COUNT = 16'h3004;

	// Reset values.
	localparam logic [15:0] FILTER_TIME_RST = 16'h0000;
	localparam logic [4:0] DUMMY_COUNT_RST = 5'h00;

	typedef enum logic [5:0] {
		LED_OFF = 6'b000001,
		LED_ON = 6'b000010,
		LED_FLICKER = 6'b000100,
		LED_BLINK = 6'b001000,
		LED_SINGLE = 6'b010000,
		LED_DOUBLE = 6'b100000
	} led_mode_t;

	typedef enum logic [2:0] {
		ST_CAPTURE = 3'b001,
		ST_RUN = 3'b010,
		ST_HALT = 3'b100
	} node_state_t;

endpackage

// ===== hw/input_debounce.sv
`timescale 1ns/10ps
module input_debounce
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Control.
	input wire logic enable_in,
	input wire logic tick_in,
	// Data.
	input wire logic raw_in,
	output logic level_out
);
	import sensor_status_pkg::*;

	logic busy_q;
	logic [1:0] count_q;

	// A transition is confirmed after four quarter-time samples all show the new level.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			level_out <= 1'b0;
			busy_q <= 1'b0;
			count_q <= 2'h0;
		end
		else if (!enable_in)
		begin
			level_out <= raw_in;
			busy_q <= 1'b0;
			count_q <= 2'h0;
		end
		else if (!busy_q)
		begin
			if (raw_in != level_out)
			begin
				busy_q <= 1'b1;
				count_q <= 2'h0;
			end
		end
		else if (tick_in)
		begin
			if (raw_in == level_out)
				busy_q <= 1'b0;
			else if (count_q == 2'(SAMPLES_NEEDED - 1))
			begin
				level_out <= raw_in;
				busy_q <= 1'b0;
			end
			else
				count_q <= count_q + 2'h1;
		end
	end

	a_filter_needs_tick: assert property (@(posedge clk_in) disable iff (rst_in)
		($past(enable_in) && level_out != $past(level_out)) |-> $past(tick_in) && $past(busy_q))
		else $error("filtered level changed without a completing sample");

endmodule

// ===== hw/indicator_pattern.sv
`timescale 1ns/10ps
module indicator_pattern
#(
	parameter int unsigned CYC_UNIT = sensor_status_pkg::CYC_50MS
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Pattern select and lamp drive.
	input wire sensor_status_pkg::led_mode_t mode_in,
	output logic led_out
);
	import sensor_status_pkg::*;

	logic [31:0] cyc_q;
	logic [1:0] sub_q;
	logic [2:0] step8_q;
	logic [2:0] step6_q;
	logic flick_q;
	led_mode_t mode_q;
	logic unit_tick;
	logic step_tick;
	logic restart;

	assign unit_tick = (cyc_q == CYC_UNIT - 1);
	assign step_tick = unit_tick && (sub_q == 2'(UNITS_PER_STEP - 1));
	assign restart = (mode_in != mode_q);

	// Counters restart on a mode change so every pattern begins with its lit phase.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cyc_q <= 32'h0;
			sub_q <= 2'h0;
			step8_q <= 3'h0;
			step6_q <= 3'h0;
			flick_q <= 1'b0;
			mode_q <= LED_OFF;
		end
		else
		begin
			mode_q <= mode_in;
			if (restart)
			begin
				cyc_q <= 32'h0;
				sub_q <= 2'h0;
				step8_q <= 3'h0;
				step6_q <= 3'h0;
				flick_q <= 1'b0;
			end
			else
			begin
				cyc_q <= unit_tick ? 32'h0 : cyc_q + 32'h1;
				if (unit_tick)
				begin
					flick_q <= ~flick_q;
					sub_q <= sub_q + 2'h1;
				end
				if (step_tick)
				begin
					step8_q <= (step8_q == 3'(DF_STEPS - 1)) ? 3'h0 : step8_q + 3'h1;
					step6_q <= (step6_q == 3'(SF_STEPS - 1)) ? 3'h0 : step6_q + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			led_out <= 1'b0;
		else
		begin
			unique case (mode_q)
				LED_OFF: led_out <= 1'b0;
				LED_ON: led_out <= 1'b1;
				LED_FLICKER: led_out <= ~flick_q;
				LED_BLINK: led_out <= ~step8_q[0];
				LED_SINGLE: led_out <= (step6_q == 3'h0);
				LED_DOUBLE: led_out <= (step8_q == 3'h0) || (step8_q == 3'h2);
				default: led_out <= 1'b0;
			endcase
		end
	end

endmodule

// ===== hw/sensor_slave_input_status.sv
`timescale 1ns/10ps
module sensor_slave_input_status
#(
	parameter int unsigned CYC_50MS = sensor_status_pkg::CYC_50MS,
	parameter int unsigned SENSORS = sensor_status_pkg::MAX_SENSORS
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Sensor outputs, index 0 is the leftmost sensor.
	input wire logic [SENSORS-1:0] first_sensor_output_in,
	input wire logic [SENSORS-1:0] second_sensor_output_in,
	// Sensor detection.
	input wire logic detect_done_in,
	input wire logic [4:0] detected_count_in,
	input wire logic [4:0] config_sensor_count_in,
	// Synchronisation mode.
	input wire logic free_run_in,
	// Mailbox object writes.
	input wire logic mbx_wr_in,
	input wire logic [15:0] mbx_index_in,
	input wire logic [15:0] mbx_data_in,
	// Input image read port.
	input wire logic image_rd_in,
	input wire logic [2:0] image_addr_in,
	output logic [7:0] image_data_out,
	// Node address.
	input wire logic [3:0] addr_sw_hundreds_in,
	input wire logic [3:0] addr_sw_tens_in,
	input wire logic [3:0] addr_sw_ones_in,
	input wire logic [15:0] tool_node_addr_in,
	input wire logic dup_addr_in,
	output logic [15:0] node_addr_out,
	output logic halted_out,
	// Error causes.
	input wire logic comm_setting_err_in,
	input wire logic sync_err_in,
	input wire logic comm_data_err_in,
	input wire logic app_watchdog_timer_to_in,
	input wire logic boot_err_in,
	input wire logic process_interface_watchdog_to_in,
	// Indicators.
	output logic err_led_out,
	output logic status_green_out,
	output logic status_red_out
);
	import sensor_status_pkg::*;

	logic [15:0] filter_time_q;
	logic [4:0] dummy_count_q;
	logic [23:0] quarter_cyc;
	logic [23:0] div_q;
	logic tick;
	logic filter_on;
	logic [2*SENSORS-1:0] raw_pairs;
	logic [2*SENSORS-1:0] level_pairs;
	logic [2*SENSORS-1:0] image_bits;
	logic [5:0] padded_sum;
	logic [4:0] padded_count;
	logic mismatch;
	logic busy;
	logic [7:0] status_byte;
	node_state_t state_q;
	logic [9:0] switch_addr_q;
	logic [9:0] switch_decoded;
	led_mode_t err_mode_q;
	logic any_err;

	// Mailbox objects that configure the filter and the dummy padding.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			filter_time_q <= FILTER_TIME_RST;
		else if (mbx_wr_in && mbx_index_in == OBJ_FILTER_TIME)
			filter_time_q <= mbx_data_in;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			dummy_count_q <= DUMMY_COUNT_RST;
		else if (mbx_wr_in && mbx_index_in == OBJ_DUMMY_COUNT)
			dummy_count_q <= (mbx_data_in > 16'(MAX_SENSORS)) ? 5'(MAX_SENSORS)
				: mbx_data_in[4:0];
	end

	// Filter time is in microseconds; one sample every quarter of it.
	assign quarter_cyc = 24'((32'(filter_time_q) * CYC_PER_US) / FILTER_DIV);
	assign filter_on = free_run_in && (filter_time_q != 16'h0000);
	assign tick = filter_on && (div_q >= quarter_cyc - 24'h1);

	// One shared divider so all inputs sample on the same edge.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			div_q <= 24'h0;
		else if (!filter_on || tick)
			div_q <= 24'h0;
		else
			div_q <= div_q + 24'h1;
	end

	// Pair layout: sensor n first output at bit 2n, second output at bit 2n+1.
	genvar g;
	generate
		for (g = 0; g < SENSORS; g++)
		begin : g_pair
			assign raw_pairs[2*g] = first_sensor_output_in[g];
			assign raw_pairs[2*g+1] = second_sensor_output_in[g];
		end
		for (g = 0; g < 2 * SENSORS; g++)
		begin : g_filter
			input_debounce u_debounce
			(
				.clk_in(clk_in),
				.rst_in(rst_in),
				.enable_in(filter_on),
				.tick_in(tick),
				.raw_in(raw_pairs[g]),
				.level_out(level_pairs[g])
			);
			// Slots past the configured count are dummy sensors and read as zero.
			assign image_bits[g] = (5'(g / 2) < config_sensor_count_in) ? level_pairs[g]
				: 1'b0;
		end
	endgenerate

	// One bit of headroom so a full count plus a full dummy count cannot wrap to zero.
	assign padded_sum = 6'(config_sensor_count_in) + 6'(dummy_count_q);
	assign padded_count = (padded_sum > 6'(MAX_SENSORS)) ? 5'(MAX_SENSORS) : padded_sum[4:0];
	assign busy = !detect_done_in;
	assign mismatch = detect_done_in && (detected_count_in != config_sensor_count_in);

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[BIT_BUSY] = busy;
		status_byte[BIT_SENSOR_FAULT] = mismatch;
	end

	// Input image read, data registered one cycle after the request.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			image_data_out <= 8'h00;
		else if (image_rd_in)
		begin
			unique case (image_addr_in)
				OFS_SENSOR_BITS_1_TO_4: image_data_out <= image_bits[7:0];
				OFS_SENSOR_BITS_5_TO_8: image_data_out <= image_bits[15:8];
				OFS_SENSOR_BITS_9_TO_12: image_data_out <= image_bits[23:16];
				OFS_SENSOR_BITS_13_TO_16: image_data_out <= image_bits[31:24];
				OFS_UNIT_STATUS_FLAGS: image_data_out <= status_byte;
				OFS_CONFIGURED_SENSOR_COUNT: image_data_out <= {3'h0, config_sensor_count_in};
				OFS_PADDED_SENSOR_COUNT: image_data_out <= {3'h0, padded_count};
				default: image_data_out <= 8'h00;
			endcase
		end
	end

	// Node address from three decimal switches, or from the tool address when the switches read zero.
	assign switch_decoded = 10'(addr_sw_hundreds_in) * 10'd100 + 10'(addr_sw_tens_in) * 10'd10
		+ 10'(addr_sw_ones_in);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_q <= ST_CAPTURE;
		else
		begin
			unique case (state_q)
				ST_CAPTURE: state_q <= ST_RUN;
				ST_RUN: state_q <= dup_addr_in ? ST_HALT : ST_RUN;
				ST_HALT: state_q <= ST_HALT;
				default: state_q <= ST_CAPTURE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			switch_addr_q <= 10'h000;
		else if (state_q == ST_CAPTURE)
			switch_addr_q <= switch_decoded;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			node_addr_out <= 16'h0000;
		else if (state_q == ST_CAPTURE)
			node_addr_out <= (switch_decoded != 10'h000) ? {6'h00, switch_decoded}
				: tool_node_addr_in;
		else if (switch_addr_q == 10'h000)
			node_addr_out <= tool_node_addr_in;
	end

	assign halted_out = (state_q == ST_HALT);

	// Error lamp pattern, most severe cause first.
	assign any_err = process_interface_watchdog_to_in || boot_err_in || app_watchdog_timer_to_in
		|| sync_err_in || comm_data_err_in || comm_setting_err_in || halted_out;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			err_mode_q <= LED_OFF;
		else if (process_interface_watchdog_to_in)
			err_mode_q <= LED_ON;
		else if (boot_err_in)
			err_mode_q <= LED_FLICKER;
		else if (app_watchdog_timer_to_in)
			err_mode_q <= LED_DOUBLE;
		else if (sync_err_in || comm_data_err_in)
			err_mode_q <= LED_SINGLE;
		else if (comm_setting_err_in || halted_out)
			err_mode_q <= LED_BLINK;
		else
			err_mode_q <= LED_OFF;
	end

	indicator_pattern #(.CYC_UNIT(CYC_50MS)) u_err_lamp
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.mode_in(err_mode_q),
		.led_out(err_led_out)
	);

	// Sensor status lamp.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_green_out <= 1'b0;
			status_red_out <= 1'b0;
		end
		else
		begin
			status_green_out <= detect_done_in && !mismatch;
			status_red_out <= mismatch;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_pdi_steady_on: assert property (
		process_interface_watchdog_to_in |=> err_mode_q == LED_ON)
		else $error("process interface watchdog did not select steady on");

	a_boot_flicker_sel: assert property (
		(boot_err_in && !process_interface_watchdog_to_in) |=> err_mode_q == LED_FLICKER)
		else $error("boot error did not select flicker");

	a_quiet_lamp_off: assert property (
		(!any_err) [*3] |=> !err_led_out)
		else $error("error lamp lit with no error");

	a_status_red_fault: assert property (
		mismatch |=> status_red_out && !status_green_out)
		else $error("mismatch did not light red");

	a_switch_address: assert property (
		(state_q == ST_CAPTURE && switch_decoded != 10'h000)
		|=> node_addr_out == {6'h00, $past(switch_decoded)})
		else $error("switch value not used as node address");

	a_tool_address: assert property (
		(state_q == ST_CAPTURE && switch_decoded == 10'h000) ##1 1'b1 [*1]
		|=> node_addr_out == $past(tool_node_addr_in))
		else $error("tool address not used with switches at zero");

	a_switch_frozen: assert property (
		(state_q != ST_CAPTURE) |=> $stable(switch_addr_q) && state_q != ST_CAPTURE)
		else $error("switches resampled after power-up");

	a_dup_halts: assert property (
		(state_q == ST_RUN && dup_addr_in) |=> halted_out ##1 halted_out)
		else $error("duplicate address did not halt");

	a_status_byte: assert property (
		(image_rd_in && image_addr_in == OFS_UNIT_STATUS_FLAGS)
		|=> image_data_out == {6'h00, $past(mismatch), $past(busy)})
		else $error("status byte wrong");

	a_first_bit: assert property (
		(image_rd_in && image_addr_in == OFS_SENSOR_BITS_1_TO_4 && config_sensor_count_in != 5'h0)
		|=> image_data_out[0] == $past(level_pairs[0]))
		else $error("sensor one first output misplaced");

	a_bypass_pass: assert property (
		!filter_on |=> level_pairs == $past(raw_pairs))
		else $error("inputs not passed through without filter");

	a_filter_setting: assert property (
		(mbx_wr_in && mbx_index_in == OBJ_FILTER_TIME) |=> filter_time_q == $past(mbx_data_in))
		else $error("filter time object not accepted");

	a_padded_clamp: assert property (
		(image_rd_in && image_addr_in == OFS_PADDED_SENSOR_COUNT
		&& config_sensor_count_in <= 5'(MAX_SENSORS))
		|=> image_data_out <= 8'(MAX_SENSORS) && image_data_out >= {3'h0, $past(config_sensor_count_in)})
		else $error("padded sensor count out of range");

	a_halt_blink_sel: assert property (
		(halted_out && !process_interface_watchdog_to_in && !boot_err_in
		&& !app_watchdog_timer_to_in && !sync_err_in && !comm_data_err_in)
		|=> err_mode_q == LED_BLINK)
		else $error("halted node did not select blink");

	a_green_normal: assert property (
		(detect_done_in && detected_count_in == config_sensor_count_in)
		|=> status_green_out && !status_red_out)
		else $error("matching sensors did not light green");

	a_status_dark: assert property (
		!detect_done_in |=> !status_green_out && !status_red_out)
		else $error("status lamp lit during sensor detection");

	c_filtered_change: cover property (filter_on && tick && level_pairs != $past(level_pairs));
	c_halt: cover property (halted_out);
	c_switch_used: cover property (state_q == ST_CAPTURE && switch_decoded != 10'h000);
	c_mismatch: cover property (status_red_out);

endmodule

// ===== tb/fieldbus_master_model.sv
`timescale 1ns/10ps
module fieldbus_master_model
(
	// Clock.
	input wire logic clk_in,
	// Image read port.
	output logic image_rd_out,
	output logic [2:0] image_addr_out,
	input wire logic [7:0] image_data_in,
	// Mailbox object writes.
	output logic mbx_wr_out,
	output logic [15:0] mbx_index_out,
	output logic [15:0] mbx_data_out
);
	initial
	begin
		image_rd_out = 1'b0;
		image_addr_out = 3'h7;
		mbx_wr_out = 1'b0;
		mbx_index_out = 16'h0000;
		mbx_data_out = 16'h0000;
	end

	// Released qualifiers are inverted so that stale values are never mistaken for a request.
	task automatic read_byte(input logic [2:0] addr, output logic [7:0] data);
		@(negedge clk_in);
		image_rd_out = 1'b1;
		image_addr_out = addr;
		@(negedge clk_in);
		image_rd_out = 1'b0;
		image_addr_out = ~addr;
		data = image_data_in;
	endtask

	task automatic write_obj(input logic [15:0] index, input logic [15:0] data);
		@(negedge clk_in);
		mbx_wr_out = 1'b1;
		mbx_index_out = index;
		mbx_data_out = data;
		@(negedge clk_in);
		mbx_wr_out = 1'b0;
		mbx_index_out = ~index;
		mbx_data_out = ~data;
	endtask
endmodule

// ===== tb/sensor_slave_input_status_tb_top.sv
`timescale 1ns/10ps
module sensor_slave_input_status_tb_top;
	logic clk_in, rst_in, detect_done, free_run, dup_addr, image_rd, mbx_wr;
	logic halted, err_led, green, red;
	logic [15:0] first, second, tool_addr, mbx_index, mbx_data, node_addr;
	logic [4:0] det_count, cfg_count;
	logic [3:0] sw_h, sw_t, sw_o;
	logic [2:0] image_addr;
	logic [7:0] image_data, b;
	logic [5:0] errs;
	int mismatches, checks, off1, on1, off2;
	int t_off1[7] = '{400, 32, 160, 160, 32, 8, 0};
	int t_on[7] = '{0, 32, 32, 32, 32, 8, 400};
	int t_off2[7] = '{400, 32, 160, 160, 160, 8, 0};

	sensor_slave_input_status #(.CYC_50MS(8), .SENSORS(16)) sensor_slave_input_status_i (
		.clk_in(clk_in), .rst_in(rst_in),
		.first_sensor_output_in(first), .second_sensor_output_in(second),
		.detect_done_in(detect_done), .detected_count_in(det_count),
		.config_sensor_count_in(cfg_count), .free_run_in(free_run),
		.mbx_wr_in(mbx_wr), .mbx_index_in(mbx_index), .mbx_data_in(mbx_data),
		.image_rd_in(image_rd), .image_addr_in(image_addr), .image_data_out(image_data),
		.addr_sw_hundreds_in(sw_h), .addr_sw_tens_in(sw_t), .addr_sw_ones_in(sw_o),
		.tool_node_addr_in(tool_addr), .dup_addr_in(dup_addr), .node_addr_out(node_addr),
		.halted_out(halted), .comm_setting_err_in(errs[0]), .sync_err_in(errs[1]),
		.comm_data_err_in(errs[2]), .app_watchdog_timer_to_in(errs[3]),
		.boot_err_in(errs[4]), .process_interface_watchdog_to_in(errs[5]),
		.err_led_out(err_led), .status_green_out(green), .status_red_out(red));

	fieldbus_master_model fieldbus_master_model_i (
		.clk_in(clk_in), .image_rd_out(image_rd), .image_addr_out(image_addr),
		.image_data_in(image_data), .mbx_wr_out(mbx_wr), .mbx_index_out(mbx_index),
		.mbx_data_out(mbx_data));

	always #5 clk_in = ~clk_in;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_time(input int got, input int exp);
		checks++;
		if (got != exp)
		begin
			mismatches++;
			$display("mismatch at %0t: lamp run %0d cycles expected %0d", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
		fieldbus_master_model_i.read_byte(addr, b);
		chk_val({8'h00, b}, {8'h00, exp});
	endtask

	function automatic logic [7:0] pack(input int n, input logic [15:0] f, input logic [15:0] s);
		logic [7:0] v;
		for (int k = 0; k < 4; k++)
		begin
			v[2*k] = f[4*n+k];
			v[2*k+1] = s[4*n+k];
		end
		return v;
	endfunction

	task automatic do_reset();
		@(negedge clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_in);
	endtask

	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (err_led === lvl && n < 400)
		begin
			@(negedge clk_in);
			n++;
		end
	endtask

	// Skips a lit run in progress, then measures off, on and off runs.
	task automatic meas();
		run_len(1'b1, on1);
		run_len(1'b0, off1);
		run_len(1'b1, on1);
		run_len(1'b0, off2);
	endtask

	task automatic t_address();
		chk_val(node_addr, 16'd123);
		sw_h = 4'h4;
		sw_o = 4'h6;
		repeat (3) @(negedge clk_in);
		chk_val(node_addr, 16'd123);
		{sw_h, sw_t, sw_o} = 12'h000;
		tool_addr = 16'hfffe;
		do_reset();
		chk_val(node_addr, 16'hfffe);
		tool_addr = 16'h0001;
		repeat (2) @(negedge clk_in);
		chk_val(node_addr, 16'h0001);
		{sw_h, sw_t, sw_o} = 12'h999;
		do_reset();
		chk_val(node_addr, 16'd999);
	endtask

	task automatic t_image();
		first = 16'ha5c3;
		second = 16'h3c96;
		repeat (3) @(negedge clk_in);
		for (int n = 0; n < 4; n++)
			rd_chk(n[2:0], pack(n, first, second));
		rd_chk(3'h4, 8'h00);
		rd_chk(3'h5, 8'h10);
		rd_chk(3'h6, 8'h10);
		rd_chk(3'h7, 8'h00);
		chk_val({green, red}, 16'h0002);
		det_count = 5'd15;
		repeat (3) @(negedge clk_in);
		rd_chk(3'h4, 8'h02);
		chk_val({green, red}, 16'h0001);
		detect_done = 1'b0;
		repeat (3) @(negedge clk_in);
		chk_val({green, red}, 16'h0000);
		fieldbus_master_model_i.read_byte(3'h4, b);
		chk_val(b[0], 16'h0001);
		detect_done = 1'b1;
		det_count = 5'd16;
	endtask

	task automatic t_dummy();
		cfg_count = 5'd10;
		det_count = 5'd10;
		fieldbus_master_model_i.write_obj(16'h3004, 16'h0003);
		rd_chk(3'h6, 8'h0d);
		rd_chk(3'h5, 8'h0a);
		// Sensors 11 and 12 lie past the configured count and read as zero.
		rd_chk(3'h2, pack(2, first, second) & 8'h0f);
		fieldbus_master_model_i.write_obj(16'h3003, 16'h0001);
		rd_chk(3'h6, 8'h0d);
		fieldbus_master_model_i.write_obj(16'h3004, 16'h0014);
		rd_chk(3'h6, 8'h10);
		cfg_count = 5'd16;
		det_count = 5'd16;
		rd_chk(3'h6, 8'h10);
	endtask

	task automatic t_filter();
		first = 16'h0000;
		second = 16'h0000;
		fieldbus_master_model_i.write_obj(16'h3002, 16'h0001);
		free_run = 1'b1;
		repeat (150) @(negedge clk_in);
		first[0] = 1'b1;
		second[15] = 1'b1;
		repeat (40) @(negedge clk_in);
		rd_chk(3'h0, 8'h00);
		repeat (100) @(negedge clk_in);
		rd_chk(3'h0, 8'h01);
		rd_chk(3'h3, 8'h80);
		first[1] = 1'b1;
		repeat (30) @(negedge clk_in);
		first[1] = 1'b0;
		repeat (150) @(negedge clk_in);
		rd_chk(3'h0, 8'h01);
		free_run = 1'b0;
		first[2] = 1'b1;
		repeat (3) @(negedge clk_in);
		rd_chk(3'h0, 8'h11);
	endtask

	task automatic t_lamps();
		for (int i = 0; i <= 6; i++)
		begin
			errs = (i == 0) ? 6'h00 : 6'h01 << (i - 1);
			repeat (4) @(negedge clk_in);
			meas();
			chk_time(off1, t_off1[i]);
			chk_time(on1, t_on[i]);
			chk_time(off2, t_off2[i]);
		end
		errs = 6'h00;
		dup_addr = 1'b1;
		@(negedge clk_in);
		dup_addr = 1'b0;
		repeat (3) @(negedge clk_in);
		chk_val(halted, 16'h0001);
		meas();
		chk_time(on1, 32);
		chk_time(off2, 32);
	endtask

	initial
	begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		{sw_h, sw_t, sw_o} = 12'h123;
		{first, second, tool_addr} = '0;
		{detect_done, free_run, dup_addr} = 3'b100;
		det_count = 5'd16;
		cfg_count = 5'd16;
		errs = 6'h00;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (2) @(negedge clk_in);
		t_address();
		t_image();
		t_dummy();
		t_filter();
		t_lamps();
		end_of_test();
	end

	initial
	begin
		repeat (60000) @(posedge clk_in);
		mismatches++;
		end_of_test();
	end
endmodule
